/* rtl/sap_pkg.sv */
// shared constants and types for secure core start-up logic
package sap_pkg;
    // exception encoding
    localparam logic [7:0] SAP_VEC_SECFAULT = 8'h1e;
    localparam logic [7:0] SAP_VEC_DBLFAULT = 8'h08;
    localparam logic [31:0] SAP_ERR_INIT_REDIR = 32'h0000_0001;
    localparam logic [31:0] SAP_ERR_DBLFAULT = 32'h0000_0000;
    // start address forming
    localparam int SAP_VEC_W = 8;
    localparam int SAP_ADDR_W = 20;
    localparam logic [11:0] SAP_PAGE_OFS = 12'h000;
    // delay before the secure-init instruction, in core cycles
    localparam int SAP_SINIT_DELAY_CYC = 1000;
    // reset values
    localparam logic SAP_GATE_RST = 1'b1;
    localparam logic SAP_FLAG_RST = 1'b0;
    // apb register byte offsets
    localparam logic [7:0] SAP_OFS_CTRL = 8'h00;
    localparam logic [7:0] SAP_OFS_VECT = 8'h04;
    localparam logic [7:0] SAP_OFS_STAT = 8'h08;
    localparam logic [7:0] SAP_OFS_ISTAT = 8'h0c;
    localparam logic [7:0] SAP_OFS_IMASK = 8'h10;
    // ctrl bits (write one to start or abort)
    localparam int SAP_CTRL_SINIT = 0;
    localparam int SAP_CTRL_STARTUP = 1;
    localparam int SAP_CTRL_ABORT = 2;
    // event bits
    localparam int SAP_EV_W = 3;
    localparam int SAP_EV_SINIT_DONE = 0;
    localparam int SAP_EV_STARTUP_SENT = 1;
    localparam int SAP_EV_ABORTED = 2;

    typedef enum logic {
        SAP_APP_RUN,
        SAP_APP_HALT
    } sap_app_st_e;

    typedef enum logic [2:0] {
        SAP_BOOT_IDLE,
        SAP_BOOT_SEND_INIT,
        SAP_BOOT_WAIT_BUSY,
        SAP_BOOT_DELAY,
        SAP_BOOT_SECURE
    } sap_boot_st_e;
endpackage : sap_pkg

/* rtl/sap_link_if.sv */
// link between the bootstrap core and one application core
`timescale 1ns/1ps
interface sap_link_if;
    logic init_ipi;
    logic startup_ipi;
    logic [7:0] startup_vec;
    logic secure_init;
    logic init_accept;
    logic in_init_state;

    modport boot (
        output init_ipi,
        output startup_ipi,
        output startup_vec,
        output secure_init,
        input init_accept,
        input in_init_state
    );
    modport app (
        input init_ipi,
        input startup_ipi,
        input startup_vec,
        input secure_init,
        output init_accept,
        output in_init_state
    );
endinterface : sap_link_if

/* rtl/sap_sync.sv */
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module sap_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // data
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= i_async;
            sync_ff <= meta_ff;
        end
    end

    assign o_sync = sync_ff;
endmodule : sap_sync

/* rtl/sap_app_core.sv */
// application core start-up, interrupt holding and init redirect
`timescale 1ns/1ps
module sap_app_core
    import sap_pkg::*;
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // link to bootstrap core
    sap_link_if.app lnk,
    // asynchronous pins
    input wire logic i_dev_irq,
    input wire logic i_smi,
    input wire logic i_nmi,
    input wire logic i_ext_init,
    // core-side controls
    input wire logic i_interrupt_flag,
    input wire logic i_gate_open,
    input wire logic i_gate_close,
    input wire logic i_vcr_clear,
    input wire logic i_dbg_clear,
    input wire logic i_contrib_busy,
    input wire logic i_irq_taken,
    // snoop port
    input wire logic i_snoop_req,
    output logic o_snoop_ack,
    // control register flags
    output logic o_global_interrupt_gate,
    output logic o_debug_disable_flag,
    output logic o_init_redirect,
    output logic o_addr_bit20_mask_disable,
    // start of execution
    output logic o_halted,
    output logic o_fetch_start,
    output logic [SAP_ADDR_W-1:0] o_fetch_addr,
    output logic o_real_mode,
    output logic o_core_reinit,
    // interrupt delivery
    output logic o_irq_deliver,
    output logic o_smi_deliver,
    output logic o_nmi_deliver,
    // exception delivery
    output logic o_exc_valid,
    output logic [7:0] o_exc_vector,
    output logic [31:0] o_exc_err,
    output logic o_exc_contrib
);
    sap_app_st_e state_ff, nxt_state;
    logic [3:0] pins_sync;
    logic [2:0] edge_prev_ff;
    logic gate_ff, dbg_ff, rinit_ff, a20_ff;
    logic nxt_gate, nxt_dbg, nxt_rinit, nxt_a20;
    logic irq_pend_ff, smi_pend_ff, nmi_pend_ff, init_pend_ff;
    logic snoop_ff, fetch_ff, real_ff, reinit_ff, accept_ff;
    logic [SAP_ADDR_W-1:0] addr_ff;
    logic irq_del_ff, smi_del_ff, nmi_del_ff;
    logic exc_ff, contrib_ff;
    logic [7:0] exc_vec_ff;
    logic [31:0] exc_err_ff;

    sap_sync #(.WIDTH(4)) u_pin_sync (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_async({i_ext_init, i_nmi, i_smi, i_dev_irq}),
        .o_sync(pins_sync)
    );

    // edges of smi, nmi and external init
    wire smi_rise = pins_sync[1] & ~edge_prev_ff[0];
    wire nmi_rise = pins_sync[2] & ~edge_prev_ff[1];
    wire init_rise = pins_sync[3] & ~edge_prev_ff[2];
    wire halted = (state_ff == SAP_APP_HALT);
    // no interrupt or init request is serviced while halted or while the gate is closed
    wire serve_ok = gate_ff & ~halted;
    wire init_ipi_go = lnk.init_ipi & ~halted & gate_ff;
    wire startup_go = lnk.startup_ipi & halted;
    wire secure_go = startup_go & lnk.secure_init;
    wire smi_pend_now = smi_pend_ff | smi_rise;
    wire nmi_pend_now = nmi_pend_ff | nmi_rise;
    wire init_pend_now = init_pend_ff | init_rise;
    // priority among held requests: init, smi, nmi
    wire init_fire = serve_ok & init_pend_now;
    wire smi_fire = serve_ok & smi_pend_now & ~init_pend_now;
    wire nmi_fire = serve_ok & nmi_pend_now & ~init_pend_now
        & ~smi_pend_now;
    wire irq_fire = serve_ok & i_interrupt_flag & irq_pend_ff
        & ~irq_del_ff;
    wire init_to_fault = init_fire & rinit_ff;
    wire init_to_reset = init_fire & ~rinit_ff;

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            SAP_APP_RUN: begin
                if (init_ipi_go) begin
                    nxt_state = SAP_APP_HALT;
                end
            end
            SAP_APP_HALT: begin
                if (startup_go) begin
                    nxt_state = SAP_APP_RUN;
                end
            end
        endcase
    end

    // startup flag setting wins over software clears
    always_comb begin
        nxt_gate = gate_ff;
        nxt_dbg = dbg_ff & ~(i_dbg_clear | i_vcr_clear);
        nxt_rinit = rinit_ff & ~i_vcr_clear;
        nxt_a20 = a20_ff & ~i_vcr_clear;
        if (i_gate_open) begin
            nxt_gate = 1'b1;
        end
        if (i_gate_close) begin
            nxt_gate = 1'b0;
        end
        if (secure_go) begin
            nxt_gate = 1'b0;
            nxt_dbg = 1'b1;
            nxt_rinit = 1'b1;
            nxt_a20 = 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_ff <= SAP_APP_RUN;
            edge_prev_ff <= '0;
            gate_ff <= SAP_GATE_RST;
            dbg_ff <= SAP_FLAG_RST;
            rinit_ff <= SAP_FLAG_RST;
            a20_ff <= SAP_FLAG_RST;
        end else begin
            state_ff <= nxt_state;
            edge_prev_ff <= pins_sync[3:1];
            gate_ff <= nxt_gate;
            dbg_ff <= nxt_dbg;
            rinit_ff <= nxt_rinit;
            a20_ff <= nxt_a20;
        end
    end

    // an smi, nmi or init fire eats one request; a second edge then stays held; irq stays pending until taken
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            irq_pend_ff <= 1'b0;
            smi_pend_ff <= 1'b0;
            nmi_pend_ff <= 1'b0;
            init_pend_ff <= 1'b0;
        end else begin
            irq_pend_ff <= pins_sync[0] | (irq_pend_ff & ~i_irq_taken);
            smi_pend_ff <= smi_fire ? smi_pend_ff & smi_rise : smi_pend_now;
            nmi_pend_ff <= nmi_fire ? nmi_pend_ff & nmi_rise : nmi_pend_now;
            init_pend_ff <= init_fire ? init_pend_ff & init_rise
                : init_pend_now;
        end
    end

    // snoops are answered in every state
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            snoop_ff <= 1'b0;
        end else begin
            snoop_ff <= i_snoop_req;
        end
    end

    // start of execution after a startup ipi
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fetch_ff <= 1'b0;
            addr_ff <= '0;
            real_ff <= 1'b0;
            reinit_ff <= 1'b0;
            accept_ff <= 1'b0;
        end else begin
            fetch_ff <= startup_go;
            accept_ff <= init_ipi_go;
            reinit_ff <= init_to_reset;
            if (startup_go) begin
                addr_ff <= {lnk.startup_vec, SAP_PAGE_OFS};
                real_ff <= 1'b1;
            end else if (init_ipi_go) begin
                real_ff <= 1'b0;
            end
        end
    end

    // interrupt and exception delivery
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            irq_del_ff <= 1'b0;
            smi_del_ff <= 1'b0;
            nmi_del_ff <= 1'b0;
            exc_ff <= 1'b0;
            exc_vec_ff <= '0;
            exc_err_ff <= '0;
            contrib_ff <= 1'b0;
        end else begin
            irq_del_ff <= irq_fire | (irq_del_ff & ~i_irq_taken);
            smi_del_ff <= smi_fire;
            nmi_del_ff <= nmi_fire;
            exc_ff <= init_to_fault;
            if (init_to_fault) begin
                contrib_ff <= 1'b1;
                // a second contributory fault escalates
                if (i_contrib_busy) begin
                    exc_vec_ff <= SAP_VEC_DBLFAULT;
                    exc_err_ff <= SAP_ERR_DBLFAULT;
                end else begin
                    exc_vec_ff <= SAP_VEC_SECFAULT;
                    exc_err_ff <= SAP_ERR_INIT_REDIR;
                end
            end
        end
    end

    assign lnk.init_accept = accept_ff;
    assign lnk.in_init_state = state_ff == SAP_APP_HALT;
    assign o_snoop_ack = snoop_ff;
    assign o_global_interrupt_gate = gate_ff;
    assign o_debug_disable_flag = dbg_ff;
    assign o_init_redirect = rinit_ff;
    assign o_addr_bit20_mask_disable = a20_ff;
    assign o_halted = state_ff == SAP_APP_HALT;
    assign o_fetch_start = fetch_ff;
    assign o_fetch_addr = addr_ff;
    assign o_real_mode = real_ff;
    assign o_core_reinit = reinit_ff;
    assign o_irq_deliver = irq_del_ff;
    assign o_smi_deliver = smi_del_ff;
    assign o_nmi_deliver = nmi_del_ff;
    assign o_exc_valid = exc_ff;
    assign o_exc_vector = exc_vec_ff;
    assign o_exc_err = exc_err_ff;
    assign o_exc_contrib = contrib_ff;
endmodule : sap_app_core

/* rtl/sap_boot_core.sv */
// bootstrap core sequencer with apb control registers
`timescale 1ns/1ps
module sap_boot_core
    import sap_pkg::*;
#(
    parameter int DELAY_CYC = SAP_SINIT_DELAY_CYC
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // system side
    input wire logic i_aps_idle,
    output logic o_irq,
    // link to application core
    sap_link_if.boot lnk
);
    sap_boot_st_e state_ff, nxt_state;
    logic [15:0] cnt_ff;
    logic [7:0] vec_ff;
    logic [SAP_EV_W-1:0] ist_ff, imask_ff, ev;
    logic pready_ff, irq_ff, init_ff, sipi_ff, secure_ff;
    logic [31:0] rdata_ff;

    wire acc = i_psel & i_penable & pready_ff;
    wire wr = acc & i_pwrite;
    wire wr_ctrl = wr & (i_paddr == SAP_OFS_CTRL);
    wire go_sinit = wr_ctrl & i_pwdata[SAP_CTRL_SINIT];
    wire go_abort = wr_ctrl & i_pwdata[SAP_CTRL_ABORT];
    // startup only once secure init is in force
    wire go_sipi = wr_ctrl & i_pwdata[SAP_CTRL_STARTUP]
        & (state_ff == SAP_BOOT_SECURE);
    wire cnt_done = cnt_ff == 16'(DELAY_CYC - 1);
    wire [31:0] stat = {28'h0, lnk.in_init_state, 3'(state_ff)};
    wire [31:0] rmux = (i_paddr == SAP_OFS_VECT) ? {24'h0, vec_ff} :
        (i_paddr == SAP_OFS_STAT) ? stat :
        (i_paddr == SAP_OFS_ISTAT) ? {29'h0, ist_ff} :
        (i_paddr == SAP_OFS_IMASK) ? {29'h0, imask_ff} : 32'h0;

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            SAP_BOOT_IDLE: begin
                if (go_sinit && i_aps_idle) begin
                    nxt_state = SAP_BOOT_SEND_INIT;
                end
            end
            SAP_BOOT_SEND_INIT: begin
                nxt_state = SAP_BOOT_WAIT_BUSY;
            end
            SAP_BOOT_WAIT_BUSY: begin
                if (lnk.init_accept) begin
                    nxt_state = SAP_BOOT_DELAY;
                end
            end
            SAP_BOOT_DELAY: begin
                if (cnt_done) begin
                    nxt_state = SAP_BOOT_SECURE;
                end
            end
            SAP_BOOT_SECURE: begin
                if (go_abort) begin
                    nxt_state = SAP_BOOT_IDLE;
                end
            end
        endcase
    end

    always_comb begin
        ev = '0;
        ev[SAP_EV_SINIT_DONE] = (state_ff == SAP_BOOT_DELAY) & cnt_done;
        ev[SAP_EV_STARTUP_SENT] = go_sipi;
        ev[SAP_EV_ABORTED] = go_abort & (state_ff == SAP_BOOT_SECURE);
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_ff <= SAP_BOOT_IDLE;
            cnt_ff <= '0;
            init_ff <= 1'b0;
            sipi_ff <= 1'b0;
            secure_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            // idle confirmed before the init ipi goes out
            init_ff <= go_sinit & i_aps_idle
                & (state_ff == SAP_BOOT_IDLE);
            sipi_ff <= go_sipi;
            // fixed wait lets the halted state settle
            cnt_ff <= (state_ff == SAP_BOOT_DELAY) ? cnt_ff + 16'h1
                : '0;
            secure_ff <= (nxt_state == SAP_BOOT_SECURE);
        end
    end

    // apb: one wait state, then the access completes
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pready_ff <= 1'b0;
            rdata_ff <= '0;
            vec_ff <= '0;
            imask_ff <= '0;
            ist_ff <= '0;
            irq_ff <= 1'b0;
        end else begin
            pready_ff <= i_psel & i_penable & ~pready_ff;
            rdata_ff <= (i_psel & i_penable & ~i_pwrite) ? rmux : 32'h0;
            if (wr && i_paddr == SAP_OFS_VECT) begin
                vec_ff <= i_pwdata[7:0];
            end
            if (wr && i_paddr == SAP_OFS_IMASK) begin
                imask_ff <= i_pwdata[SAP_EV_W-1:0];
            end
            // new event wins over a write-one clear
            ist_ff <= (ist_ff & ~((wr && i_paddr == SAP_OFS_ISTAT) ?
                i_pwdata[SAP_EV_W-1:0] : '0)) | ev;
            irq_ff <= |(ist_ff & imask_ff);
        end
    end

    assign lnk.init_ipi = init_ff;
    assign lnk.startup_ipi = sipi_ff;
    assign lnk.startup_vec = vec_ff;
    assign lnk.secure_init = secure_ff;
    assign o_prdata = rdata_ff;
    assign o_pready = pready_ff;
    assign o_pslverr = 1'b0;
    assign o_irq = irq_ff;
endmodule : sap_boot_core

/* sim/sap_assertions.sv */
// link-level assertions between the bootstrap and application cores
`timescale 1ns/1ps
module sap_assertions #(
    parameter int DELAY_CYC = 1000
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // link signals
    input wire logic init_ipi,
    input wire logic startup_ipi,
    input wire logic [7:0] startup_vec,
    input wire logic secure_init,
    input wire logic init_accept,
    input wire logic in_init_state
);
    // a few cycles of slack for the state hand-offs around the delay
    localparam int SEC_MAX = DELAY_CYC + 4;

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_accepted;
        init_accept && in_init_state;
    endsequence
    sequence s_woken;
        !in_init_state && !init_accept;
    endsequence

    a_accept_caused: assert property (init_accept |-> $past(init_ipi))
        else $error("init accept without a preceding init ipi");
    a_accept_halts: assert property (init_accept |-> s_accepted)
        else $error("init accept without the halted state");
    a_halt_entry: assert property ($rose(in_init_state) |-> s_accepted)
        else $error("halted state entered without an accept");
    a_halt_holds: assert property (
        in_init_state && !startup_ipi |=> in_init_state)
        else $error("halted state left without a startup ipi");
    a_startup_wakes: assert property (
        in_init_state && startup_ipi |=> s_woken)
        else $error("startup ipi did not end the halted state");
    a_accept_pulse: assert property (init_accept |=> !init_accept)
        else $error("init accept longer than one cycle");
    a_halted_refuses: assert property (
        in_init_state && init_ipi |=> !init_accept)
        else $error("init ipi accepted while halted");
    a_secure_delay: assert property (
        init_accept |-> ##[1:SEC_MAX] secure_init)
        else $error("secure init not raised in time after accept");
    a_secure_halted: assert property (
        $rose(secure_init) |-> in_init_state)
        else $error("secure init raised with the core not halted");
    a_startup_secure: assert property (startup_ipi |-> secure_init)
        else $error("startup ipi sent without secure init");
endmodule : sap_assertions

/* sim/sap_bench.sv */
// self-checking bench: boot core and application core joined by the link
`timescale 1ns/1ps
module sap_bench;
    import sap_pkg::*;
    // short delay keeps the run brief; the checker gets the same value
    localparam int DLY = 4;
    logic i_sys_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic psel, penable, pwrite, aps_idle, pready, pslverr, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic dev_irq, smi, nmi, ext_init, iflag, g_open, g_close;
    logic vcr_clr, dbg_clr, contrib, irq_taken, snoop, snoop_ack;
    logic gate, dbg, rinit, a20, halted, fetch, real_md, reinit;
    logic irq_dlv, smi_dlv, nmi_dlv, exc_v, exc_c;
    logic [19:0] faddr;
    logic [7:0] exc_vec;
    logic [31:0] exc_err;
    int fail_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    int smi_n = 0;
    int nmi_n = 0;
    int reinit_n = 0;
    int exc_n = 0;

    sap_link_if u_sap_link_if ();
    sap_boot_core #(.DELAY_CYC(DLY)) u_sap_boot_core (
        .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_aps_idle(aps_idle), .o_irq(irq),
        .lnk(u_sap_link_if.boot));
    sap_app_core u_sap_app_core (
        .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .lnk(u_sap_link_if.app),
        .i_dev_irq(dev_irq), .i_smi(smi), .i_nmi(nmi), .i_ext_init(ext_init),
        .i_interrupt_flag(iflag), .i_gate_open(g_open),
        .i_gate_close(g_close), .i_vcr_clear(vcr_clr),
        .i_dbg_clear(dbg_clr), .i_contrib_busy(contrib),
        .i_irq_taken(irq_taken), .i_snoop_req(snoop), .o_snoop_ack(snoop_ack),
        .o_global_interrupt_gate(gate), .o_debug_disable_flag(dbg),
        .o_init_redirect(rinit), .o_addr_bit20_mask_disable(a20),
        .o_halted(halted), .o_fetch_start(fetch), .o_fetch_addr(faddr),
        .o_real_mode(real_md), .o_core_reinit(reinit),
        .o_irq_deliver(irq_dlv), .o_smi_deliver(smi_dlv),
        .o_nmi_deliver(nmi_dlv), .o_exc_valid(exc_v), .o_exc_vector(exc_vec),
        .o_exc_err(exc_err), .o_exc_contrib(exc_c));
    sap_assertions #(.DELAY_CYC(DLY)) u_sap_assertions (
        .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
        .init_ipi(u_sap_link_if.init_ipi),
        .startup_ipi(u_sap_link_if.startup_ipi),
        .startup_vec(u_sap_link_if.startup_vec),
        .secure_init(u_sap_link_if.secure_init),
        .init_accept(u_sap_link_if.init_accept),
        .in_init_state(u_sap_link_if.in_init_state));

    always #2.5 i_sys_clk = ~i_sys_clk;

    // pulse counters and the hang guard
    always @(posedge i_sys_clk) begin
        cyc++;
        smi_n += int'(smi_dlv === 1'b1);
        nmi_n += int'(nmi_dlv === 1'b1);
        reinit_n += int'(reinit === 1'b1);
        exc_n += int'(exc_v === 1'b1);
        if (cyc == 4000) begin
            fail_count++;
            stop_test();
        end
    end

    task stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : stop_test

    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task tick;
        @(posedge i_sys_clk);
        #1;
    endtask : tick

    // one apb transfer; read data lands in rd at the completing edge
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge i_sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge i_sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge i_sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        chk("pready", 32'h1, 32'(n < 50));
        chk("pslverr", 32'h0, 32'(pslverr));
    endtask : apb

    initial begin
        {psel, penable, pwrite, aps_idle, paddr, pwdata} = '0;
        {dev_irq, smi, nmi, ext_init, iflag, g_open, g_close} = '0;
        {vcr_clr, dbg_clr, contrib, irq_taken, snoop} = '0;
        repeat (5) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        tick();
        chk("gate_rst", 32'h1, 32'(gate));
        chk("flags_rst", 32'h0, {28'h0, dbg, rinit, a20, halted});
        apb(1'b0, SAP_OFS_STAT, 32'h0);
        chk("stat_rst", 32'h0, rd);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped", 32'h0, rd);
        // device irq raised with the interrupt flag clear stays pending
        @(posedge i_sys_clk);
        dev_irq <= 1'b1;
        aps_idle <= 1'b1;
        apb(1'b1, SAP_OFS_IMASK, 32'h7);
        apb(1'b1, SAP_OFS_CTRL, 32'h1 << SAP_CTRL_SINIT);
        for (int n = 0; n < 20 && u_sap_link_if.in_init_state !== 1'b1; n++)
            tick();
        chk("halted", 32'h1, 32'(halted));
        @(posedge i_sys_clk);
        {snoop, smi, nmi} <= 3'h7;
        tick();
        tick();
        chk("snoop_ack", 32'h1, 32'(snoop_ack));
        @(posedge i_sys_clk);
        {snoop, smi, nmi} <= 3'h0;
        rd = 32'h0;
        for (int n = 0; n < 20 && rd[2:0] !== 3'h4; n++)
            apb(1'b0, SAP_OFS_STAT, 32'h0);
        chk("stat_secure", 32'hc, rd);
        chk("secure_init", 32'h1, 32'(u_sap_link_if.secure_init));
        apb(1'b0, SAP_OFS_ISTAT, 32'h0);
        chk("istat_done", 32'h1, rd);
        // masked event drops the line, clear keeps it down after unmasking
        apb(1'b1, SAP_OFS_IMASK, 32'h0);
        tick();
        chk("irq_masked", 32'h0, 32'(irq));
        apb(1'b1, SAP_OFS_ISTAT, 32'h1);
        apb(1'b1, SAP_OFS_IMASK, 32'h7);
        tick();
        chk("irq_cleared", 32'h0, 32'(irq));
        apb(1'b1, SAP_OFS_VECT, 32'h9c);
        apb(1'b1, SAP_OFS_CTRL, 32'h1 << SAP_CTRL_STARTUP);
        for (int n = 0; n < 20 && fetch !== 1'b1; n++)
            tick();
        chk("fetch_addr", 32'h9c000, {12'h0, faddr});
        chk("real_mode", 32'h1, 32'(real_md));
        chk("startup", 32'he, {27'h0, gate, dbg, rinit, a20, halted});
        chk("smi_held", 32'h0, smi_n);
        chk("nmi_held", 32'h0, nmi_n);
        @(posedge i_sys_clk);
        iflag <= 1'b1;
        repeat (4) tick();
        chk("irq_gate_shut", 32'h0, 32'(irq_dlv));
        @(posedge i_sys_clk);
        g_open <= 1'b1;
        @(posedge i_sys_clk);
        g_open <= 1'b0;
        repeat (8) tick();
        chk("smi_freed", 32'h1, smi_n);
        chk("nmi_freed", 32'h1, nmi_n);
        chk("irq_freed", 32'h1, 32'(irq_dlv));
        @(posedge i_sys_clk);
        {dev_irq, ext_init} <= 2'h1;
        for (int n = 0; n < 20 && exc_v !== 1'b1; n++)
            tick();
        chk("sx_vector", 32'h1e, {24'h0, exc_vec});
        chk("sx_error", 32'h1, exc_err);
        chk("sx_contrib", 32'h1, 32'(exc_c));
        chk("no_reinit", 32'h0, reinit_n);
        @(posedge i_sys_clk);
        {ext_init, contrib, irq_taken} <= 3'h3;
        @(posedge i_sys_clk);
        irq_taken <= 1'b0;
        tick();
        chk("irq_taken", 32'h0, 32'(irq_dlv));
        @(posedge i_sys_clk);
        ext_init <= 1'b1;
        for (int n = 0; n < 20 && exc_v !== 1'b1; n++)
            tick();
        chk("double_vector", 32'h8, {24'h0, exc_vec});
        chk("double_error", 32'h0, exc_err);
        @(posedge i_sys_clk);
        {ext_init, contrib, dbg_clr} <= 3'h1;
        @(posedge i_sys_clk);
        dbg_clr <= 1'b0;
        tick();
        chk("dbg_clear", 32'h3, {29'h0, dbg, rinit, a20});
        @(posedge i_sys_clk);
        vcr_clr <= 1'b1;
        @(posedge i_sys_clk);
        vcr_clr <= 1'b0;
        tick();
        chk("vcr_clear", 32'h0, {29'h0, dbg, rinit, a20});
        @(posedge i_sys_clk);
        ext_init <= 1'b1;
        repeat (8) tick();
        chk("plain_reinit", 32'h1, reinit_n);
        chk("exc_count", 32'h2, exc_n);
        apb(1'b1, SAP_OFS_CTRL, 32'h1 << SAP_CTRL_ABORT);
        apb(1'b0, SAP_OFS_STAT, 32'h0);
        chk("stat_abort", 32'h0, rd);
        apb(1'b0, SAP_OFS_ISTAT, 32'h0);
        chk("istat_abort", 32'h6, rd);
        chk("irq_abort", 32'h1, 32'(irq));
        chk("secure_off", 32'h0, 32'(u_sap_link_if.secure_init));
        // with the gate shut a fresh init ipi must be ignored
        @(posedge i_sys_clk);
        g_close <= 1'b1;
        @(posedge i_sys_clk);
        g_close <= 1'b0;
        apb(1'b1, SAP_OFS_CTRL, 32'h1 << SAP_CTRL_SINIT);
        repeat (6) tick();
        chk("gate_shut", 32'h0, 32'(gate));
        chk("no_halt", 32'h0, 32'(halted));
        stop_test();
    end
endmodule : sap_bench
